// >>> rtl/bet_pkg.sv
// Purpose: Constants for the bank error triage block
// Assumes: APB slave, one clock, 32-bit data
package bet_pkg;
    localparam logic [7:0]  ADDR_CAP        = 8'h00;
    localparam logic [7:0]  ADDR_GSTAT      = 8'h04;
    localparam logic [7:0]  ADDR_EVENT      = 8'h08;
    localparam logic [7:0]  ADDR_CLASS_BASE = 8'h10;
    localparam int          CAP_RECOV_BIT   = 24;
    localparam int          GST_RIP_BIT     = 0;
    localparam int          GST_FIP_BIT     = 1;
    localparam int          GST_FLIGHT_BIT  = 2;
    localparam int          GST_SHUT_BIT    = 3;
    localparam int          EVT_CONS_BIT    = 0;
    localparam logic        CAP_RESET       = 1'b1;
    localparam logic [2:0]  CLS_NONE        = 3'h0;
    localparam logic [2:0]  CLS_CORRECTED   = 3'h1;
    localparam logic [2:0]  CLS_NO_ACTION   = 3'h2;
    localparam logic [2:0]  CLS_OPT_FIX     = 3'h3;
    localparam logic [2:0]  CLS_MAND_FIX    = 3'h4;
    localparam logic [2:0]  CLS_SPURIOUS    = 3'h5;
    localparam logic [2:0]  CLS_FATAL       = 3'h6;
    localparam int          MAX_BANKS       = 8;
endpackage

// >>> rtl/bet_triage.sv
// Purpose: Classifies each error bank and raises check or corrected-error events
// Assumes: Bank flags synchronous to I_CLK_SYS, one bit per bank
// Notes:   APB answers with zero wait states; read data is captured in setup
`timescale 1ns/1ns
module bet_triage
    import bet_pkg::*;
#(
    parameter int NUM_BANKS = 4
) (
    input  wire logic                 I_CLK_SYS,
    input  wire logic                 I_RESET_N,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [NUM_BANKS-1:0] i_entry_good,
    input  wire logic [NUM_BANKS-1:0] i_not_fixed,
    input  wire logic [NUM_BANKS-1:0] i_error_armed,
    input  wire logic [NUM_BANKS-1:0] i_context_corrupt,
    input  wire logic [NUM_BANKS-1:0] i_recov_by_handler,
    input  wire logic [NUM_BANKS-1:0] i_action_needed,
    input  wire logic [NUM_BANKS-1:0] i_lost_prior_info,
    input  wire logic [NUM_BANKS-1:0] i_data_consumed,
    input  wire logic                 i_restart_ip_good,
    input  wire logic                 i_faulting_ip_linked,
    output logic      [3*NUM_BANKS-1:0] o_bank_class,
    output logic                      o_machine_check,
    output logic                      o_corrected_error_irq,
    output logic                      o_check_in_flight,
    output logic                      o_shutdown
);

    if (NUM_BANKS < 1 || NUM_BANKS > MAX_BANKS) begin : g_bad_banks
        $error("NUM_BANKS out of range");
    end

    typedef struct packed {
        logic [3*NUM_BANKS-1:0] cls;
        logic [NUM_BANKS-1:0]   good_prev;
        logic                   cap;
        logic                   rip;
        logic                   fip;
        logic                   flight;
        logic                   shut;
        logic                   cons;
        logic                   mce;
        logic                   cirq;
        logic                   slverr;
        logic [31:0]            rdata;
    } bet_state_t;

    bet_state_t st_q;
    bet_state_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Per-bank classification
    logic [3*NUM_BANKS-1:0] cls_now;
    logic [NUM_BANKS-1:0]   mce_new;
    logic [NUM_BANKS-1:0]   cirq_new;
    logic [NUM_BANKS-1:0]   consume;

    // Same order as the handler walks a bank; spurious is tested before context damage
    function automatic logic [2:0] classify(input logic good, input logic nf, input logic armed,
                                            input logic cc, input logic rbh, input logic an,
                                            input logic lost, input logic cap);
        logic [2:0] c;
        c = CLS_NONE;
        if (!good) begin
            c = CLS_NONE;
        end else if (!nf) begin
            c = CLS_CORRECTED;
        end else if (!cap) begin
            c = CLS_FATAL;
        end else if (!armed && !lost) begin
            c = CLS_SPURIOUS;
        end else if (cc) begin
            c = CLS_FATAL;
        end else if (!rbh && !an) begin
            c = CLS_NO_ACTION;
        end else if (!rbh) begin
            c = CLS_FATAL;
        end else if (!an) begin
            c = CLS_OPT_FIX;
        end else begin
            c = CLS_MAND_FIX;
        end
        return c;
    endfunction

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic [2:0] c;
        logic       fresh;
        assign c = classify(i_entry_good[b], i_not_fixed[b], i_error_armed[b], i_context_corrupt[b],
                            i_recov_by_handler[b], i_action_needed[b], i_lost_prior_info[b], st_q.cap);
        assign cls_now[3*b +: 3] = c;
        // A bank reports a new error only in the cycle after its entry_good rises
        assign fresh = i_entry_good[b] && !st_q.good_prev[b];
        // Armed errors classed fix or fatal go to the check; corrected, no-action and spurious to the notification
        assign mce_new[b] = fresh && i_not_fixed[b] && i_error_armed[b]
                            && (c == CLS_OPT_FIX || c == CLS_MAND_FIX || c == CLS_FATAL);
        assign cirq_new[b] = fresh && (c == CLS_CORRECTED || c == CLS_NO_ACTION
                                       || c == CLS_SPURIOUS);
        assign consume[b] = i_data_consumed[b] && st_q.cls[3*b +: 3] == CLS_NO_ACTION;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and next state
    logic       setup;
    logic       wr_acc;
    logic [5:0] widx;
    logic       mce_fire;

    assign setup    = i_psel && !i_penable;
    assign wr_acc   = i_psel && i_penable && i_pwrite;
    assign widx     = i_paddr[7:2] - ADDR_CLASS_BASE[7:2];
    assign mce_fire = |mce_new || |consume;

    always_comb begin
        st_d           = st_q;
        st_d.cls       = cls_now;
        st_d.good_prev = i_entry_good;
        st_d.mce       = mce_fire;
        st_d.cirq      = |cirq_new;
        if (mce_fire) begin
            st_d.rip  = i_restart_ip_good;
            st_d.fip  = i_faulting_ip_linked;
            st_d.cons = |consume && !(|mce_new);
        end
        if (mce_fire && st_q.flight) begin
            st_d.shut = 1'b1;
        end
        if (wr_acc && i_paddr == ADDR_CAP) begin
            st_d.cap = i_pwdata[CAP_RECOV_BIT];
        end
        // Software may only clear the flag; a new check in the same cycle wins
        if (wr_acc && i_paddr == ADDR_GSTAT && !i_pwdata[GST_FLIGHT_BIT]) begin
            st_d.flight = 1'b0;
        end
        if (mce_fire) begin
            st_d.flight = 1'b1;
        end
        if (setup) begin
            st_d.rdata  = 32'h0;
            st_d.slverr = 1'b0;
            if (i_paddr == ADDR_CAP) begin
                st_d.rdata[CAP_RECOV_BIT] = st_q.cap;
            end else if (i_paddr == ADDR_GSTAT) begin
                st_d.rdata[GST_RIP_BIT]    = st_q.rip;
                st_d.rdata[GST_FIP_BIT]    = st_q.fip;
                st_d.rdata[GST_FLIGHT_BIT] = st_q.flight;
                st_d.rdata[GST_SHUT_BIT]   = st_q.shut;
            end else if (i_paddr == ADDR_EVENT) begin
                st_d.rdata[EVT_CONS_BIT] = st_q.cons;
            end else if (i_paddr[1:0] == 2'h0 && i_paddr >= ADDR_CLASS_BASE
                         && 32'(widx) < NUM_BANKS) begin
                st_d.rdata[2:0] = st_q.cls[3*widx +: 3];
            end else begin
                st_d.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_q     <= '0;
            st_q.cap <= CAP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_prdata              = st_q.rdata;
    assign o_pready              = 1'b1;
    assign o_pslverr             = st_q.slverr;
    assign o_bank_class          = st_q.cls;
    assign o_machine_check       = st_q.mce;
    assign o_corrected_error_irq = st_q.cirq;
    assign o_check_in_flight     = st_q.flight;
    assign o_shutdown            = st_q.shut;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);

    sequence s_uncorrected_no_action_arrives;
        i_entry_good[0] && !st_q.good_prev[0] && i_not_fixed[0] && st_q.cap && !i_context_corrupt[0]
        && !i_recov_by_handler[0] && !i_action_needed[0] && (i_error_armed[0] || i_lost_prior_info[0]);
    endsequence

    chk_invalid_none: assert property (!i_entry_good[0] |=> o_bank_class[2:0] == CLS_NONE)
        else $error("invalid bank not classed none");
    chk_corrected_cls: assert property (i_entry_good[0] && !i_not_fixed[0]
        |=> o_bank_class[2:0] == CLS_CORRECTED) else $error("corrected bank misclassed");
    chk_nocap_fatal: assert property (i_entry_good[0] && i_not_fixed[0] && !st_q.cap
        |=> o_bank_class[2:0] == CLS_FATAL) else $error("no recovery support but not fatal");
    chk_recov_class: assert property (i_entry_good[0] && i_not_fixed[0] && i_error_armed[0]
        && !i_context_corrupt[0] && i_recov_by_handler[0] && st_q.cap
        |=> o_bank_class[2:0] == CLS_OPT_FIX || o_bank_class[2:0] == CLS_MAND_FIX)
        else $error("recoverable error misclassed");
    chk_uncorrected_no_action_notify: assert property (s_uncorrected_no_action_arrives
        |=> o_corrected_error_irq && o_bank_class[2:0] == CLS_NO_ACTION)
        else $error("no-action error not notified");
    chk_armed_check: assert property (i_entry_good[0] && !st_q.good_prev[0] && i_not_fixed[0]
        && i_error_armed[0] && i_recov_by_handler[0] && st_q.cap && !i_context_corrupt[0]
        |=> o_machine_check && o_check_in_flight) else $error("recoverable error without check");
    chk_consume_check: assert property (i_data_consumed[0]
        && o_bank_class[2:0] == CLS_NO_ACTION |=> o_machine_check)
        else $error("consumed no-action data without check");
    chk_nested_shut: assert property (o_check_in_flight && mce_fire
        |=> o_shutdown ##1 o_shutdown) else $error("nested check did not shut down");
    chk_flight_hold: assert property (o_check_in_flight && !wr_acc
        |=> o_check_in_flight) else $error("in-flight flag dropped without write");
    // Shutdown is sticky and a check always sets the in-flight flag
    chk_shut_sticky: assert property (o_shutdown |=> o_shutdown)
        else $error("shutdown dropped without reset");
    chk_flight_set: assert property (mce_fire |=> o_check_in_flight)
        else $error("check did not set in-flight flag");

endmodule

// >>> tb/bet_handler_bfm.sv
// Purpose: APB master standing in for the handler software
// Assumes: Slave may add wait states; the master waits for pready
// Notes:   Every signal changes by NBA just after a rising edge
`timescale 1ns/1ns
module bet_handler_bfm (
    input  wire logic        i_clk,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // Request held until pready is seen high; data taken at that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= wd;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the bank error triage block
// Assumes: Restart pointer good and faulting pointer unlinked until the no-recovery tests
// Notes:   Bank flags change right after a rising edge
`timescale 1ns/1ns
module tb_top;
    import bet_pkg::*;
    localparam int NB = 4;
    logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              err, rip, fip, mc, irq, flight, shut;
    logic [NB-1:0]     eg, nf, ar, cc, rbh, an, lost, cons;
    logic [3*NB-1:0]   cls;
    logic [1:0]        pulse;
    logic [12:0]       tbl [9];
    int                b;
    int                failures;
    int                compares;

    bet_handler_bfm u_bfm (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
    bet_triage #(.NUM_BANKS(NB)) u_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_entry_good(eg), .i_not_fixed(nf), .i_error_armed(ar),
        .i_context_corrupt(cc), .i_recov_by_handler(rbh), .i_action_needed(an), .i_lost_prior_info(lost),
        .i_data_consumed(cons), .i_restart_ip_good(rip), .i_faulting_ip_linked(fip), .o_bank_class(cls),
        .o_machine_check(mc), .o_corrected_error_irq(irq), .o_check_in_flight(flight), .o_shutdown(shut));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        u_bfm.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        u_bfm.xfer(1'b1, a, d, rd, err);
    endtask

    // New error on bank b; pulses captured in the cycle they stand
    task automatic hit(input int b, input logic [5:0] f);
        @(posedge clk);
        eg[b] <= 1'b1;
        {nf[b], ar[b], cc[b], rbh[b], an[b], lost[b]} <= f;
        @(posedge clk);
        #1;
        pulse = {mc, irq};
    endtask

    task automatic clr(input int b);
        @(posedge clk);
        {eg[b], nf[b], ar[b], cc[b], rbh[b], an[b], lost[b]} <= 7'h0;
        @(posedge clk);
        #1;
        chk({29'h0, cls[3*b+:3]}, {29'h0, CLS_NONE});
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial begin
        failures = 0;
        compares = 0;
        {eg, nf, ar, cc, rbh, an, lost, cons} = '0;
        rip = 1'b1;
        fip = 1'b0;
        rst_n = 1'b0;
        // Bank, flags {nf,ar,cc,rbh,an,lost}, class, {check,irq}
        tbl = '{13'b00_000000_001_01, 13'b00_110000_010_01, 13'b10_110100_011_10, 13'b11_110110_100_10,
                13'b00_110101_011_10, 13'b01_110111_100_10, 13'b10_100000_101_01, 13'b11_111100_110_10,
                13'b10_110010_110_10};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({27'h0, mc, irq, flight, shut, pready}, 32'h1);
        rd_reg(ADDR_CAP, 32'h0100_0000, 1'b0);
        rd_reg(8'h0c, 32'h0, 1'b1);
        rd_reg(8'h02, 32'h0, 1'b1);
        wr_reg(ADDR_CLASS_BASE, 32'h7);
        rd_reg(ADDR_CLASS_BASE, 32'h0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            b = int'(tbl[i][12:11]);
            hit(b, tbl[i][10:5]);
            chk({29'h0, cls[3*b+:3]}, {29'h0, tbl[i][4:2]});
            chk({30'h0, pulse}, {30'h0, tbl[i][1:0]});
            rd_reg(ADDR_CLASS_BASE + 8'(4 * b), {29'h0, tbl[i][4:2]}, 1'b0);
            if (i == 1) begin
                @(posedge clk);
                cons[b] <= 1'b1;
                @(posedge clk);
                cons[b] <= 1'b0;
                #1;
                chk({31'h0, mc}, 32'h1);
                rd_reg(ADDR_EVENT, 32'h1, 1'b0);
            end
            if (tbl[i][1])
                rd_reg(ADDR_GSTAT, 32'h5, 1'b0);
            wr_reg(ADDR_GSTAT, 32'h0);
            #1;
            chk({31'h0, flight}, 32'h0);
            clr(b);
        end
        wr_reg(ADDR_CAP, 32'h0);
        rd_reg(ADDR_CAP, 32'h0, 1'b0);
        rip <= 1'b0;
        fip <= 1'b1;
        hit(0, 6'b110100);
        chk({29'h0, cls[2:0]}, {29'h0, CLS_FATAL});
        rd_reg(ADDR_GSTAT, 32'h6, 1'b0);
        wr_reg(ADDR_GSTAT, 32'h0);
        hit(1, 6'b100000);
        chk({29'h0, cls[5:3]}, {29'h0, CLS_FATAL});
        wr_reg(ADDR_GSTAT, 32'h0);
        chk({31'h0, shut}, 32'h0);
        hit(2, 6'b110100);
        hit(3, 6'b110110);
        @(posedge clk);
        #1;
        chk({31'h0, shut}, 32'h1);
        wr_reg(ADDR_GSTAT, 32'h0);
        chk({31'h0, shut}, 32'h1);
        @(posedge clk);
        {eg, nf, ar, cc, rbh, an, lost} <= '0;
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({30'h0, flight, shut}, 32'h0);
        rd_reg(ADDR_CAP, 32'h0100_0000, 1'b0);
        end_of_test();
    end
endmodule
